// >>> rtl/psb_defs.vh
/*
 * Constants for the phase-shift bridge sequencer: register offsets,
 * field positions, reset values and start-up count.
 * Assumes inclusion by bare name from the sequencer module.
 */
`ifndef PSB_DEFS_VH
`define PSB_DEFS_VH

// register byte offsets on the 32-bit bus
`define PSB_ADR_CTRL      8'h00
`define PSB_ADR_DEAD_AB   8'h04
`define PSB_ADR_DEAD_CD   8'h08
`define PSB_ADR_DEAD_SEC  8'h0C
`define PSB_ADR_STATUS    8'h10

// control fields
`define PSB_CTRL_EN_BIT   0
`define PSB_CTRL_CLR_BIT  1

// status fields
`define PSB_ST_SUPN_BIT   0
`define PSB_ST_HALT_BIT   1
`define PSB_ST_LIM_BIT    2
`define PSB_ST_HALF_BIT   3
`define PSB_ST_LL_BIT     4
`define PSB_ST_STATE_LSB  8

// reset values
`define PSB_RST_CTRL_EN   1'b1
`define PSB_RST_DEAD_AB   8'h08
`define PSB_RST_DEAD_CD   8'h08
`define PSB_RST_DEAD_SEC  8'h04

// oscillator clocks counted before operation starts
`define PSB_STARTUP_COUNT 6'h20

`endif

// >>> rtl/psb_sequencer.v
/*
 * Phase-shift full-bridge sequencer: start-up counter, bridge and
 * secondary rectifier ordering with dead times, fault handling and a
 * classic Wishbone register slave.
 * Assumes all inputs synchronous to clk_i; osc_tick_i is a one-cycle
 * strobe per oscillator clock; fault and phase inputs are digital flags.
 */
// Chosen here: the register offsets and register access over Wishbone.
// Functional notes
// RL1: outputs stay low until the active-low supply-good level goes low.
// RL2: supply-good asserts after 32 oscillator clocks of remote-on and ref-good.
// RL3: loss of ref-good or remote-on drops operation at once, no count.
// RL4: one master drives the sync line, at most four slaves attach.
// RL5: with external sync, own oscillator at most half the master clock.
// RL6: external master clock on the sync input at most 4 MHz.
// RL7: four bridge outputs A-D, two secondary outputs E-F, programmable dead times.
// RL8: power transfer holds A and D on, E off, F on.
// RL9: after D turns off, C turns on once the C/D dead time elapses.
// RL10: with C on, A turns off at the next oscillator clock, starting freewheel.
// RL11: after A turns off, F turns off after the secondary dead time.
// RL12: after A turns off, B turns on after the A/B dead time.
// RL13: then the same sequence runs mirrored for the other half cycle.
// RL14: light load forces zero secondary dead time.
// RL15: after a cycle current limit, next secondary transition has zero dead time.
// RL16: a C/D toggle by the phase comparison restores secondary dead time.
// RL17: one-shot over-current forces E and F low and halts switching.
// RL18: remote off drives all six outputs low.
// RL19: three dead times are counts loaded at reset, used per transition group.
// RL20: faults are digital flags; the phase point is a comparison strobe.
`include "psb_defs.vh"
`default_nettype none

module psb_sequencer #(
  parameter DW = 8
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone slave
  input  wire [7:0]  adr_i,
  input  wire [31:0] dat_i,
  input  wire [3:0]  sel_i,
  input  wire        we_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // analog front-end flags
  input  wire        osc_tick_i,
  input  wire        remote_on_i,
  input  wire        ref_good_i,
  input  wire        light_load_i,
  input  wire        cycle_current_limit_i,
  input  wire        one_shot_ocp_i,
  input  wire        phase_point_i,
  // gate outputs
  output reg         out_a_o,
  output reg         out_b_o,
  output reg         out_c_o,
  output reg         out_d_o,
  output reg         out_e_o,
  output reg         out_f_o,
  output reg         supply_ok_n_o
);

  localparam [2:0] ST_IDLE   = 3'h0;
  localparam [2:0] ST_POWER  = 3'h1;
  localparam [2:0] ST_CDDEAD = 3'h2;
  localparam [2:0] ST_WAITA  = 3'h3;
  localparam [2:0] ST_ABDEAD = 3'h4;

  reg          ctrl_en;
  // dead times in clk_i counts
  reg [DW-1:0] leg_ab_dead_time;
  reg [DW-1:0] leg_cd_dead_time;
  reg [DW-1:0] secondary_dead_time;
  reg [5:0]    start_cnt;
  reg          halted;
  reg          limit_flag;
  reg          half;
  reg [2:0]    state;
  reg [DW-1:0] dead_cnt;
  reg [DW-1:0] sec_cnt;
  reg          sec_run;

  wire bus_req;
  wire wr_req;
  wire start_ok;
  wire start_last;
  wire run;
  wire zero_sec;
  wire cd_toggle;

  assign bus_req    = cyc_i & stb_i & ~ack_o;
  // a write lands at the edge on which the master samples ack high
  assign wr_req     = cyc_i & stb_i & we_i & ack_o;
  assign start_ok   = remote_on_i & ref_good_i;
  assign start_last = (start_cnt == `PSB_STARTUP_COUNT - 6'h01);
  assign run        = ~supply_ok_n_o & ~halted & ctrl_en;
  // light load or a recent limit event: no secondary dead time
  assign zero_sec   = light_load_i | limit_flag;
  assign cd_toggle  = phase_point_i | cycle_current_limit_i;

  // byte-lane merge for the 8-bit fields in lane 0
  function [DW-1:0] lane0;
    input [DW-1:0] old;
    input [31:0]   data;
    input [3:0]    sel;
    begin
      lane0 = sel[0] ? data[DW-1:0] : old;
    end
  endfunction

  // one count down; never wraps, zero is tested first
  function [DW-1:0] count_down;
    input [DW-1:0] cnt;
    begin
      count_down = cnt - {{(DW-1){1'b0}}, 1'b1};
    end
  endfunction

  // zero test shared by all three timers
  function count_done;
    input [DW-1:0] cnt;
    begin
      count_done = (cnt == {DW{1'b0}});
    end
  endfunction

  // wishbone slave: ack one cycle after the request, dropped next cycle
  // unmapped addresses still ack, so a stray access cannot hang the bus
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o               <= 1'b0;
      dat_o               <= 32'h0000_0000;
      ctrl_en             <= `PSB_RST_CTRL_EN;
      leg_ab_dead_time    <= `PSB_RST_DEAD_AB; // RL19
      leg_cd_dead_time    <= `PSB_RST_DEAD_CD; // RL19
      secondary_dead_time <= `PSB_RST_DEAD_SEC; // RL19
    end else begin
      ack_o <= bus_req;
      dat_o <= 32'h0000_0000;
      if (wr_req) begin
        case (adr_i)
          `PSB_ADR_CTRL:
            if (sel_i[0])
              ctrl_en <= dat_i[`PSB_CTRL_EN_BIT];
          `PSB_ADR_DEAD_AB:
            leg_ab_dead_time <= lane0(leg_ab_dead_time, dat_i, sel_i);
          `PSB_ADR_DEAD_CD:
            leg_cd_dead_time <= lane0(leg_cd_dead_time, dat_i, sel_i);
          `PSB_ADR_DEAD_SEC:
            secondary_dead_time <= lane0(secondary_dead_time, dat_i, sel_i);
          default: ;
        endcase
      end
      if (bus_req && !we_i) begin
        case (adr_i)
          `PSB_ADR_CTRL:
            dat_o[`PSB_CTRL_EN_BIT] <= ctrl_en;
          `PSB_ADR_DEAD_AB:
            dat_o[DW-1:0] <= leg_ab_dead_time;
          `PSB_ADR_DEAD_CD:
            dat_o[DW-1:0] <= leg_cd_dead_time;
          `PSB_ADR_DEAD_SEC:
            dat_o[DW-1:0] <= secondary_dead_time;
          `PSB_ADR_STATUS: begin
            dat_o[`PSB_ST_SUPN_BIT] <= supply_ok_n_o;
            dat_o[`PSB_ST_HALT_BIT] <= halted;
            dat_o[`PSB_ST_LIM_BIT]  <= limit_flag;
            dat_o[`PSB_ST_HALF_BIT] <= half;
            dat_o[`PSB_ST_LL_BIT]   <= light_load_i;
            dat_o[`PSB_ST_STATE_LSB+2:`PSB_ST_STATE_LSB] <= state;
          end
          default: ;
        endcase
      end
    end
  end

  // start-up counter: counts on the way up only
  always @(posedge clk_i) begin
    if (rst_i) begin
      start_cnt     <= 6'h00;
      supply_ok_n_o <= 1'b1;
    // no count on the way down: a dropout stops switching at once
    end else if (!start_ok) begin
      start_cnt     <= 6'h00; // RL3
      supply_ok_n_o <= 1'b1; // RL3
    // ticks may come from a shared sync line; fan-out is a board limit
    end else if (supply_ok_n_o && osc_tick_i) begin // RL4
      if (start_last)
        supply_ok_n_o <= 1'b0; // RL2
      else
        start_cnt <= start_cnt + 6'h01; // RL2
    end
  end

  // one-shot over-current latches until the supply drops out (supply_ok_n_o high)
  // cleared only by a restart, so a fault cannot resume silently
  always @(posedge clk_i) begin
    if (rst_i)
      halted <= 1'b0;
    else if (one_shot_ocp_i)
      halted <= 1'b1; // RL17
    else if (supply_ok_n_o)
      halted <= 1'b0;
  end

  // bridge and secondary sequencing
  always @(posedge clk_i) begin
    if (rst_i || !run) begin
      // remote off, supply not good, halted or ctrl_en cleared: everything low
      state      <= ST_IDLE; // RL1 RL18 RL17
      half       <= 1'b0;
      dead_cnt   <= {DW{1'b0}};
      sec_cnt    <= {DW{1'b0}};
      sec_run    <= 1'b0;
      limit_flag <= 1'b0;
      out_a_o    <= 1'b0;
      out_b_o    <= 1'b0;
      out_c_o    <= 1'b0;
      out_d_o    <= 1'b0;
      out_e_o    <= 1'b0; // RL17
      out_f_o    <= 1'b0; // RL17
    end else begin
      // limit event sets, a phase toggle clears; the set wins
      if (cycle_current_limit_i)
        limit_flag <= 1'b1; // RL15
      else if (state == ST_POWER && phase_point_i)
        limit_flag <= 1'b0; // RL16
      // secondary turn-off timer runs beside the A/B dead time
      if (sec_run) begin
        if (count_done(sec_cnt) || zero_sec) begin
          sec_run <= 1'b0;
          if (half)
            out_e_o <= 1'b0; // RL13
          else
            out_f_o <= 1'b0; // RL11
        end else
          sec_cnt <= count_down(sec_cnt);
      end
      case (state) // RL7
        ST_IDLE: begin
          // first power interval on the edge after start
          out_a_o <= 1'b1; // RL8
          out_d_o <= 1'b1; // RL8
          out_e_o <= 1'b0; // RL8
          out_f_o <= 1'b1; // RL8
          state   <= ST_POWER;
        end
        ST_POWER:
          // lagging leg toggles on phase point or current limit
          // E rises with D off; no gap on that edge
          if (cd_toggle) begin // RL20
            if (half) begin
              out_c_o <= 1'b0; // RL13
              out_f_o <= 1'b1;
            end else begin
              out_d_o <= 1'b0; // RL9
              out_e_o <= 1'b1;
            end
            dead_cnt <= leg_cd_dead_time; // RL19
            state    <= ST_CDDEAD;
          end
        ST_CDDEAD:
          if (count_done(dead_cnt)) begin
            if (half)
              out_d_o <= 1'b1; // RL13
            else
              out_c_o <= 1'b1; // RL9
            state <= ST_WAITA;
          end else
            dead_cnt <= count_down(dead_cnt);
        ST_WAITA:
          // leading leg turns off at the next oscillator edge
          if (osc_tick_i) begin
            if (half)
              out_b_o <= 1'b0; // RL13
            else
              out_a_o <= 1'b0; // RL10
            // A/B and secondary timers start together from A off
            dead_cnt <= leg_ab_dead_time; // RL19
            sec_cnt  <= secondary_dead_time; // RL19
            sec_run  <= 1'b1; // RL11 RL14 RL15
            state    <= ST_ABDEAD;
          end
        ST_ABDEAD:
          if (count_done(dead_cnt)) begin
            if (half)
              out_a_o <= 1'b1; // RL13
            else
              out_b_o <= 1'b1; // RL12
            half  <= ~half; // RL13
            state <= ST_POWER;
          end else
            dead_cnt <= count_down(dead_cnt);
        default:
          state <= ST_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

// >>> testbench/psb_sequencer_monitor.sv
/* checker on the sequencer ports.
   assumes dead-time registers at reset values 8, 8 and 4 */
`default_nettype none
module psb_sequencer_monitor (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // flags
  input wire osc_tick_i, remote_on_i, ref_good_i, light_load_i,
  input wire cycle_current_limit_i, one_shot_ocp_i, phase_point_i,
  // gates
  input wire out_a_o, out_b_o, out_c_o, out_d_o, out_e_o, out_f_o,
  input wire supply_ok_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] ticks;
  logic       lim;
  wire        any_on = out_a_o | out_b_o | out_c_o | out_d_o | out_e_o
                       | out_f_o;
  // counts ticks only while both start conditions hold
  always @(posedge clk_i) begin
    ticks <= (rst_i || !(remote_on_i && ref_good_i)) ? 6'h00
             : ticks + {5'h00, osc_tick_i && ticks < 6'h20};
    lim <= !rst_i && (cycle_current_limit_i || lim && !phase_point_i);
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence gap(x);
    ##1 (!x)[*8] ##1 x;
  endsequence
  supply_drop_a: assert property (
    !(remote_on_i && ref_good_i) |=> supply_ok_n_o) else $error("no drop");
  startup_count_a: assert property (
    $fell(supply_ok_n_o) |-> ticks == 6'h20) else $error("bad count");
  idle_quiet_a: assert property (
    supply_ok_n_o |=> !any_on) else $error("gate on while idle");
  power_half_a: assert property (
    out_a_o && out_d_o |-> !out_e_o && out_f_o) else $error("power half");
  mirror_half_a: assert property (
    out_b_o && out_c_o |-> out_e_o && !out_f_o) else $error("mirror half");
  cd_dead_a: assert property (
    $fell(out_d_o) && out_e_o |-> gap(out_c_o || !out_e_o))
    else $error("c/d dead time");
  ab_dead_a: assert property (
    $fell(out_a_o) && out_c_o |-> gap(out_b_o || !out_c_o))
    else $error("a/b dead time");
  sec_dead_a: assert property (
    $fell(out_a_o) && out_c_o && !light_load_i && !lim
    |-> out_f_o[*5] ##1 !out_f_o) else $error("secondary dead time");
  sec_zero_a: assert property (
    $fell(out_a_o) && out_c_o && (light_load_i || lim) |=> !out_f_o)
    else $error("secondary not immediate");
  ocp_halt_a: assert property (
    one_shot_ocp_i |-> ##2 !any_on) else $error("no halt");
endmodule
`default_nettype wire

// >>> testbench/psb_gate_drv.sv
/* gate driver model for both bridge legs.
   assumes registered active-high gate levels, order a..f */
`default_nettype none
module psb_gate_drv (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire  [5:0] gate_i,
  output logic       fault_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // both switches of a leg on shorts the supply, so it latches
  always @(posedge clk_i)
    fault_o <= !rst_i && (fault_o || gate_i[5] && gate_i[4]
               || gate_i[3] && gate_i[2]);
endmodule
`default_nettype wire

// >>> testbench/psb_sequencer_tb.sv
/* self-checking bench for the sequencer.
   assumes the gate driver model and the bound checker */
`default_nettype none
module psb_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct { logic l; logic [3:0] t; logic [5:0] g; } psb_row_t;
  psb_row_t    rows [6] = '{'{1'h0, 4'h4, 6'h1A}, '{1'h0, 4'h4, 6'h25},
    '{1'h1, 4'h4, 6'h1A}, '{1'h1, 4'h4, 6'h25}, '{1'h0, 4'h2, 6'h1A},
    '{1'h0, 4'h4, 6'h25}};
  logic [31:0] rv [6] = '{32'h1, 32'h8, 32'h8, 32'h4, 32'h1, 32'h0};
  logic        clk_i = 1'h0, rst_i = 1'h1, we = 1'h0, cyc = 1'h0;
  logic        rem = 1'h0, refg = 1'h0, ll = 1'h0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  pz = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  wire  [31:0] dat_o;
  wire  [5:0]  gates;
  wire         ack_o, sup_n, fault;
  int          n_mismatch = 0;
  int          compares = 0;
  always #20 clk_i = ~clk_i;
  psb_sequencer i_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr),
    .dat_i(wdat), .sel_i(4'hF), .we_i(we), .cyc_i(cyc), .stb_i(cyc),
    .dat_o(dat_o), .ack_o(ack_o), .osc_tick_i(pz[0]), .remote_on_i(rem),
    .ref_good_i(refg), .light_load_i(ll), .cycle_current_limit_i(pz[1]),
    .one_shot_ocp_i(pz[3]), .phase_point_i(pz[2]), .out_a_o(gates[5]),
    .out_b_o(gates[4]), .out_c_o(gates[3]), .out_d_o(gates[2]),
    .out_e_o(gates[1]), .out_f_o(gates[0]), .supply_ok_n_o(sup_n));
  psb_gate_drv i_drv (.clk_i(clk_i), .rst_i(rst_i), .gate_i(gates),
    .fault_o(fault));
  task automatic chk(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // pulses last one cycle, then n-1 more edges pass
  task automatic step(input logic [3:0] v, input int n);
    pz <= v;
    @(posedge clk_i);
    pz <= 4'h0;
    repeat (n - 1) @(posedge clk_i);
  endtask
  // waits for ack as long as it takes; only the watchdog ends a hang
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    adr <= a;
    we <= w;
    wdat <= d;
    cyc <= 1'h1;
    do @(posedge clk_i); while (ack_o !== 1'h1);
    rdat = dat_o;
    cyc <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic start();
    rem <= 1'h1;
    refg <= 1'h1;
    repeat (31) step(4'h1, 13);
    chk("early supply", 32'h1, {31'h0, sup_n});
    step(4'h1, 3);
    chk("supply", 32'h0, {31'h0, sup_n});
    chk("power", 32'h25, {26'h0, gates});
  endtask
  task automatic results();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    n_mismatch++;
    results();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'h0;
    chk("reset gates", 32'h0, {26'h0, gates});
    foreach (rv[i]) begin
      wb(8'(i * 4), 1'h0, 32'h0);
      chk("register", rv[i], rdat);
    end
    wb(8'h04, 1'h1, 32'h3C);
    wb(8'h04, 1'h0, 32'h0);
    chk("dead write", 32'h3C, rdat);
    wb(8'h04, 1'h1, 32'h8);
    wb(8'h10, 1'h1, 32'hFF);
    wb(8'h14, 1'h1, 32'hFF);
    wb(8'h14, 1'h0, 32'h0);
    chk("unmapped", 32'h0, rdat);
    wb(8'h10, 1'h0, 32'h0);
    chk("status", 32'h1, rdat);
    start();
    foreach (rows[i]) begin
      ll <= rows[i].l;
      step(rows[i].t, 12);
      step(4'h1, 14);
      chk("gates", {26'h0, rows[i].g}, {26'h0, gates});
    end
    wb(8'h00, 1'h1, 32'h0);
    step(4'h0, 2);
    chk("disabled", 32'h0, {26'h0, gates});
    wb(8'h00, 1'h1, 32'h1);
    step(4'h0, 3);
    chk("enabled", 32'h25, {26'h0, gates});
    rem <= 1'h0;
    step(4'h0, 3);
    chk("remote off", 32'h1, {26'h0, gates, sup_n});
    start();
    step(4'h8, 3);
    chk("ocp gates", 32'h0, {26'h0, gates});
    wb(8'h10, 1'h0, 32'h0);
    chk("halted", 32'h2, rdat & 32'h3);
    refg <= 1'h0;
    step(4'h0, 2);
    chk("ref loss", 32'h1, {31'h0, sup_n});
    chk("overlap", 32'h0, {31'h0, fault});
    results();
  end
endmodule
bind psb_sequencer psb_sequencer_monitor i_mon (.*);
`default_nettype wire
